// ===== plb_err_counter.sv
// Received-error counter that clears itself when read.
`timescale 1ns/100ps
module plb_err_counter (
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Error type selection.
    input  wire logic        count_symbol_errors,
    input  wire logic        count_false_carrier,
    // Error events, one-cycle pulses.
    input  wire logic        crc_error,
    input  wire logic        symbol_error,
    input  wire logic        false_carrier,
    // Clear on read and current count.
    input  wire logic        clear,
    output logic      [15:0] count
);

    typedef struct packed {
        logic [15:0] count;
    } plb_cnt_t;

    plb_cnt_t    st;
    plb_cnt_t    next_st;
    logic [1:0]  inc;
    logic [16:0] sum;

    // Pick the counted events; an event in the clearing cycle is still counted.
    always_comb begin
        inc = {1'b0, count_symbol_errors ? symbol_error : crc_error}
            + {1'b0, count_false_carrier & false_carrier};
        sum = {1'b0, clear ? plb_pkg::ERR_RESET : st.count} + {15'h0000, inc};
        next_st.count = sum[16] ? plb_pkg::ERR_MAX : sum[15:0];
    end

    // Register the count.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st.count <= plb_pkg::ERR_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign count = st.count;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    AST_ERR_CLEAR: assert property (
        clear && inc == 2'h0 |=> count == 16'h0000)
        else $error("Counter not cleared by a read.");

    AST_ERR_CRC: assert property (
        !clear && !count_symbol_errors && !count_false_carrier && crc_error
        && count != plb_pkg::ERR_MAX |=> count == $past(count) + 16'h0001)
        else $error("CRC error not counted.");

    AST_ERR_SYMBOL_ONLY: assert property (
        count_symbol_errors && !symbol_error && !clear
        && !(count_false_carrier && false_carrier) |=> $stable(count))
        else $error("Counter moved with no selected event.");

endmodule : plb_err_counter

// ===== plb_mdio_host.sv
// Station management model that drives management frames onto the serial port.
`timescale 1ns/100ps
module plb_mdio_host (
    // Clock.
    input  wire logic sys_clk,
    // Device side of the data pin.
    input  wire logic mdio_out,
    input  wire logic mdio_oe,
    // Management clock and resolved data level.
    output logic      mdc,
    output logic      mdio_in
);
    logic drv_en;
    logic drv;

    // The pin has a pull-up, so it reads one when nobody drives it.
    assign mdio_in = mdio_oe ? mdio_out : (drv_en ? drv : 1'b1);

    // The management clock stands low between frames.
    initial begin
        mdc    = 1'b0;
        drv_en = 1'b0;
        drv    = 1'b1;
    end

    // One frame; data changes with the falling clock and is sampled just before the rise.
    task automatic frame(input logic [4:0] pa, input logic [1:0] op, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] bits;
        bits = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
        rd   = 16'h0000;
        for (int i = 63; i >= 0; i--) begin
            @(negedge sys_clk);
            mdc    = 1'b0;
            drv_en = (op == plb_pkg::OP_WRITE) || (i >= 18);
            drv    = bits[i];
            repeat (8) @(negedge sys_clk);
            if (i < 16) rd[i] = mdio_in;
            mdc = 1'b1;
            repeat (7) @(negedge sys_clk);
        end
        @(negedge sys_clk);
        mdc    = 1'b0;
        drv_en = 1'b0;
    endtask : frame
endmodule : plb_mdio_host

// ===== plb_phy_loopback_diag_regs.sv
// Loopback control, received-error counter and energy-detect registers behind a management port.
`timescale 1ns/100ps
// Summary of operation
// - Loopback control bit 10 enables line-driver loopback, resets to zero.
// - Loopback control bit 9 enables remote loopback, resets to zero.
// - Loopback control bit 7 enables external-cable loopback, resets to zero.
// - Bit 6, reset one, suppresses transmit during all-digital loopback.
// - In MII loopback link status follows force bit 0, which resets to one.
// - In other loopback modes link status is set only when link comes up.
// - MII loopback ready after milliseconds; remote never; others when link status set.
// - Sixteen-bit read-only error counter resets to zero, clears when read.
// - Counts CRC errors, or symbol errors, plus false carrier when selected.
// - Energy-detect bit 3, reset one, enables energy-detect power-down.
// - Energy-detect bit 2, reset one, allows link pulses during power-down.
// - Loopback control bit 15 selects MII loopback; bit 12 enables all-digital.
module plb_phy_loopback_diag_regs #(
    parameter logic [4:0] PHY_ADDR         = plb_pkg::PHY_ADDR_DEF,
    parameter int         MII_READY_CYCLES = plb_pkg::MII_READY_CYCLES
) (
    // Clock and reset.
    input  wire logic sys_clk,
    input  wire logic rst,
    // Management serial port; the data pin is split into three signals.
    input  wire logic mdc,
    input  wire logic mdio_in,
    output logic      mdio_out,
    output logic      mdio_oe,
    // Settings held elsewhere in the PHY.
    input  wire logic general_loopback,
    input  wire logic count_symbol_errors,
    input  wire logic count_false_carrier,
    // Link and receive events from the PHY core.
    input  wire logic link_up,
    input  wire logic crc_error,
    input  wire logic symbol_error,
    input  wire logic false_carrier,
    // Loopback controls.
    output logic      mii_loop_sel,
    output logic      all_digital_en,
    output logic      line_driver_en,
    output logic      remote_en,
    output logic      ext_cable_en,
    output logic      tx_suppress,
    // Status.
    output logic      link_status,
    output logic      phy_ready,
    // Energy-detect power-down controls.
    output logic      edpd_en,
    output logic      edpd_nlp_en
);

    typedef struct packed {
        plb_pkg::plb_mdio_state_t state;
        logic                     mdc_prev;
        logic [5:0]               ones;
        logic [4:0]               bits;
        logic [15:0]              sh;
        logic                     is_read;
        logic                     hit;
        logic [4:0]               regad;
        logic                     mdio_out;
        logic                     mdio_oe;
        logic [15:0]              lb;
        logic [15:0]              ed;
        logic [15:0]              mii_timer;
        logic                     link_status;
        logic                     phy_ready;
        logic                     tx_suppress;
    } plb_state_t;

    localparam logic [15:0] MII_LIMIT = MII_READY_CYCLES[15:0];

    plb_state_t  st;
    plb_state_t  next_st;
    logic [1:0]  pins_s;
    logic        mdc_s;
    logic        mdio_s;
    logic        rise;
    logic [11:0] hv;
    logic [15:0] wd;
    logic [15:0] rd_val;
    logic        rd_clear;
    logic        wr_lb;
    logic        wr_ed;
    logic [15:0] err_count;
    logic        mii_act;
    logic        dig_act;
    logic        rem_act;
    logic        loop_act;

    // Bring the management clock and data into the core clock domain.
    plb_sync2 #(
        .W    (2)
    ) u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .din     ({mdc, mdio_in}),
        .dout    (pins_s)
    );

    assign mdc_s  = pins_s[1];
    assign mdio_s = pins_s[0];
    assign rise   = mdc_s & ~st.mdc_prev;

    // Received-error counter, cleared when its read data is loaded.
    plb_err_counter u_err (
        .sys_clk             (sys_clk),
        .rst                 (rst),
        .count_symbol_errors (count_symbol_errors),
        .count_false_carrier (count_false_carrier),
        .crc_error           (crc_error),
        .symbol_error        (symbol_error),
        .false_carrier       (false_carrier),
        .clear               (rd_clear),
        .count               (err_count)
    );

    // Loopback mode decode; the general loopback bit is set by software as each mode needs.
    always_comb begin
        mii_act  = general_loopback & st.lb[plb_pkg::LB_MII_BIT];
        dig_act  = general_loopback & st.lb[plb_pkg::LB_DIGITAL_BIT]
                 & ~st.lb[plb_pkg::LB_MII_BIT];
        rem_act  = ~general_loopback & st.lb[plb_pkg::LB_REMOTE_BIT];
        loop_act = dig_act | rem_act
                 | (general_loopback & st.lb[plb_pkg::LB_LINE_BIT])
                 | (~general_loopback & st.lb[plb_pkg::LB_EXT_BIT]);
    end

    // Frame decode helpers and read data; unmapped addresses read as zero.
    always_comb begin
        hv = {st.sh[10:0], mdio_s};
        wd = {st.sh[14:0], mdio_s};
        case (st.regad)
            plb_pkg::REG_LOOPBACK: rd_val = st.lb;
            plb_pkg::REG_RX_ERR:   rd_val = err_count;
            plb_pkg::REG_ED_CTRL:  rd_val = st.ed;
            default:               rd_val = 16'h0000;
        endcase
        rd_clear = rise && st.state == plb_pkg::S_TA && st.bits != 5'h00
                 && st.is_read && st.hit && st.regad == plb_pkg::REG_RX_ERR;
        wr_lb    = rise && st.state == plb_pkg::S_WR && st.bits == plb_pkg::DATA_LAST
                 && st.hit && st.regad == plb_pkg::REG_LOOPBACK;
        wr_ed    = rise && st.state == plb_pkg::S_WR && st.bits == plb_pkg::DATA_LAST
                 && st.hit && st.regad == plb_pkg::REG_ED_CTRL;
    end

    // Next-state logic: frame receiver, register writes and status.
    always_comb begin
        next_st          = st;
        next_st.mdc_prev = mdc_s;
        if (rise) begin
            case (st.state)
                plb_pkg::S_IDLE: begin
                    if (!mdio_s) begin
                        next_st.ones = 6'h00;
                        if (st.ones == plb_pkg::PREAMBLE_LEN) begin
                            next_st.state = plb_pkg::S_START;
                        end
                    end else if (st.ones != plb_pkg::PREAMBLE_LEN) begin
                        next_st.ones = st.ones + 6'h01;
                    end
                end
                plb_pkg::S_START: begin
                    next_st.bits  = 5'h00;
                    next_st.state = mdio_s ? plb_pkg::S_HDR : plb_pkg::S_IDLE;
                end
                plb_pkg::S_HDR: begin
                    next_st.sh   = {st.sh[14:0], mdio_s};
                    next_st.bits = st.bits + 5'h01;
                    // The twelfth header bit is sampled now; earlier ones sit in sh[10:0].
                    if (st.bits == plb_pkg::HDR_LAST) begin
                        next_st.is_read = hv[11:10] == plb_pkg::OP_READ;
                        next_st.hit     = hv[9:5] == PHY_ADDR;
                        next_st.regad   = hv[4:0];
                        next_st.bits    = 5'h00;
                        next_st.state   = (hv[11:10] == plb_pkg::OP_READ
                                        || hv[11:10] == plb_pkg::OP_WRITE)
                                        ? plb_pkg::S_TA : plb_pkg::S_IDLE;
                    end
                end
                plb_pkg::S_TA: begin
                    next_st.bits = 5'h01;
                    if (st.bits == 5'h00) begin
                        // On a read, the second turnaround bit is driven low by the addressed device.
                        next_st.mdio_out = 1'b0;
                        next_st.mdio_oe  = st.is_read & st.hit;
                    end else begin
                        next_st.bits     = 5'h00;
                        next_st.sh       = rd_val;
                        next_st.mdio_out = rd_val[15];
                        next_st.state    = st.is_read ? plb_pkg::S_RD : plb_pkg::S_WR;
                    end
                end
                plb_pkg::S_RD: begin
                    next_st.sh       = {st.sh[14:0], 1'b0};
                    next_st.mdio_out = st.sh[14];
                    next_st.bits     = st.bits + 5'h01;
                    if (st.bits == plb_pkg::DATA_LAST) begin
                        next_st.mdio_oe  = 1'b0;
                        next_st.mdio_out = 1'b0;
                        next_st.state    = plb_pkg::S_IDLE;
                    end
                end
                plb_pkg::S_WR: begin
                    next_st.sh   = wd;
                    next_st.bits = st.bits + 5'h01;
                    if (st.bits == plb_pkg::DATA_LAST) begin
                        next_st.state = plb_pkg::S_IDLE;
                    end
                end
                default: begin
                    next_st.state = plb_pkg::S_IDLE;
                end
            endcase
        end
        // Writes keep only defined bits; reserved bits stay zero.
        if (wr_lb) begin
            next_st.lb = wd & plb_pkg::LB_MASK;
        end
        if (wr_ed) begin
            next_st.ed = wd & plb_pkg::ED_MASK;
        end
        // Settling timer runs only while MII loopback is active.
        if (!mii_act) begin
            next_st.mii_timer = 16'h0000;
        end else if (st.mii_timer != MII_LIMIT) begin
            next_st.mii_timer = st.mii_timer + 16'h0001;
        end
        next_st.link_status = mii_act ? st.lb[plb_pkg::LB_FORCE_BIT] : link_up;
        next_st.phy_ready   = mii_act ? st.mii_timer == MII_LIMIT
                            : rem_act ? 1'b0 : next_st.link_status;
        next_st.tx_suppress = dig_act & st.lb[plb_pkg::LB_TXSUP_BIT];
    end

    // Register the whole state.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st    <= '0;
            st.lb <= plb_pkg::LB_RESET;
            st.ed <= plb_pkg::ED_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Outputs come straight from the state flops.
    assign mdio_out       = st.mdio_out;
    assign mdio_oe        = st.mdio_oe;
    assign mii_loop_sel   = st.lb[plb_pkg::LB_MII_BIT];
    assign all_digital_en = st.lb[plb_pkg::LB_DIGITAL_BIT];
    assign line_driver_en = st.lb[plb_pkg::LB_LINE_BIT];
    assign remote_en      = st.lb[plb_pkg::LB_REMOTE_BIT];
    assign ext_cable_en   = st.lb[plb_pkg::LB_EXT_BIT];
    assign tx_suppress    = st.tx_suppress;
    assign link_status    = st.link_status;
    assign phy_ready      = st.phy_ready;
    assign edpd_en        = st.ed[plb_pkg::ED_EN_BIT];
    assign edpd_nlp_en    = st.ed[plb_pkg::ED_NLP_BIT];

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    AST_LINE_WRITE: assert property (
        wr_lb |=> line_driver_en == $past(wd[10]))
        else $error("Line-driver loopback bit not written.");

    AST_REMOTE_EXT_WRITE: assert property (
        wr_lb |=> remote_en == $past(wd[9]) && ext_cable_en == $past(wd[7]))
        else $error("Remote or external-cable bit not written.");

    AST_MII_DIG_WRITE: assert property (
        wr_lb |=> mii_loop_sel == $past(wd[15]) && all_digital_en == $past(wd[12]))
        else $error("MII or all-digital bit not written.");

    AST_TX_SUPPRESS: assert property (
        general_loopback && !mii_loop_sel && all_digital_en && st.lb[6]
        && $stable(general_loopback) && $stable(st.lb) |=> tx_suppress)
        else $error("Transmit not suppressed in all-digital loopback.");

    AST_MII_LINK: assert property (
        mii_act |=> link_status == $past(st.lb[0]))
        else $error("Link status does not follow force bit in MII loopback.");

    AST_OTHER_LINK: assert property (
        loop_act && !mii_act |=> link_status == $past(link_up))
        else $error("Link status not tied to link in loopback.");

    AST_MII_READY_WAIT: assert property (
        $rose(mii_act) |=> !phy_ready [*3])
        else $error("Ready too soon after entering MII loopback.");

    AST_REMOTE_NEVER: assert property (
        rem_act && !mii_act |=> !phy_ready)
        else $error("Ready asserted in remote loopback.");

    AST_ED_WRITE: assert property (
        wr_ed |=> edpd_en == $past(wd[3]) && edpd_nlp_en == $past(wd[2]))
        else $error("Energy-detect bits not written.");

    AST_RESERVED_ZERO: assert property (
        (st.lb & ~plb_pkg::LB_MASK) == 16'h0000 && (st.ed & ~plb_pkg::ED_MASK) == 16'h0000)
        else $error("Reserved bit set.");

endmodule : plb_phy_loopback_diag_regs

// ===== plb_pkg.sv
// Shared constants and types for the loopback and diagnostic register bank.
package plb_pkg;

    // Register addresses on the management interface.
    localparam logic [4:0]  REG_LOOPBACK   = 5'h13;
    localparam logic [4:0]  REG_RX_ERR     = 5'h14;
    localparam logic [4:0]  REG_ED_CTRL    = 5'h15;

    // Loopback control field positions.
    localparam int          LB_MII_BIT     = 15;
    localparam int          LB_DIGITAL_BIT = 12;
    localparam int          LB_LINE_BIT    = 10;
    localparam int          LB_REMOTE_BIT  = 9;
    localparam int          LB_EXT_BIT     = 7;
    localparam int          LB_TXSUP_BIT   = 6;
    localparam int          LB_FORCE_BIT   = 0;

    // Energy-detect control field positions.
    localparam int          ED_EN_BIT      = 3;
    localparam int          ED_NLP_BIT     = 2;

    // Writable bits, values after reset and the error count limit.
    localparam logic [15:0] LB_MASK        = 16'h96c1;
    localparam logic [15:0] LB_RESET       = 16'h1041;
    localparam logic [15:0] ED_MASK        = 16'h000c;
    localparam logic [15:0] ED_RESET       = 16'h000c;
    localparam logic [15:0] ERR_RESET      = 16'h0000;
    localparam logic [15:0] ERR_MAX        = 16'hffff;

    // Management frame layout.
    localparam logic [5:0]  PREAMBLE_LEN   = 6'h20;
    localparam logic [4:0]  HDR_LAST       = 5'h0b;
    localparam logic [4:0]  DATA_LAST      = 5'h0f;
    localparam logic [1:0]  OP_READ        = 2'h2;
    localparam logic [1:0]  OP_WRITE       = 2'h1;
    localparam logic [4:0]  PHY_ADDR_DEF   = 5'h01;

    // Settling time before data is accepted in MII loopback.
    localparam int          CLK_HZ             = 20000000;
    localparam int          MII_READY_TIME_MS  = 2;
    localparam int          MII_READY_CYCLES   = MII_READY_TIME_MS * (CLK_HZ / 1000);

    // Management frame receiver states.
    typedef enum logic [2:0] {
        S_IDLE,
        S_START,
        S_HDR,
        S_TA,
        S_RD,
        S_WR
    } plb_mdio_state_t;

endpackage : plb_pkg

// ===== plb_sync2.sv
// Two-flop synchroniser for a group of asynchronous inputs.
`timescale 1ns/100ps
module plb_sync2 #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         sys_clk,
    input  wire logic         rst,
    // Asynchronous input and synchronised output.
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } plb_sync_t;

    plb_sync_t st;
    plb_sync_t next_st;

    // The first stage feeds only the second stage.
    always_comb begin
        next_st.meta   = din;
        next_st.stable = st.meta;
    end

    // Register both stages.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.stable;

endmodule : plb_sync2

// ===== testbench.sv
// Self-checking bench for the loopback and diagnostic register bank.
`timescale 1ns/100ps
module testbench;
    logic        sys_clk, rst, mdc, mdio_in, mdio_out, mdio_oe;
    logic        general_loopback, count_symbol_errors, count_false_carrier;
    logic        link_up, crc_error, symbol_error, false_carrier;
    logic        mii_loop_sel, all_digital_en, line_driver_en, remote_en, ext_cable_en;
    logic        tx_suppress, link_status, phy_ready, edpd_en, edpd_nlp_en;
    logic [15:0] ctl_ports;
    int          errors, num_checks, cycles;
    // Loopback settings and expected {general_loopback, link_up, link, ready, suppress}.
    logic [15:0] lb_tab [7] = '{16'h1040, 16'h1000, 16'h0400, 16'h0080, 16'h0200, 16'h8000,
                                16'h8001};
    logic [4:0]  io_tab [7] = '{5'h11, 5'h1e, 5'h1e, 5'h0e, 5'h0c, 5'h1a, 5'h16};

    // Control outputs gathered into one word for compact comparisons.
    assign ctl_ports = {8'h00, mii_loop_sel, all_digital_en, line_driver_en, remote_en,
                        ext_cable_en, tx_suppress, edpd_en, edpd_nlp_en};

    plb_phy_loopback_diag_regs #(.PHY_ADDR(5'h01), .MII_READY_CYCLES(40)) dut (
        .sys_clk(sys_clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
        .mdio_oe(mdio_oe), .general_loopback(general_loopback),
        .count_symbol_errors(count_symbol_errors), .count_false_carrier(count_false_carrier),
        .link_up(link_up), .crc_error(crc_error), .symbol_error(symbol_error),
        .false_carrier(false_carrier), .mii_loop_sel(mii_loop_sel),
        .all_digital_en(all_digital_en), .line_driver_en(line_driver_en),
        .remote_en(remote_en), .ext_cable_en(ext_cable_en), .tx_suppress(tx_suppress),
        .link_status(link_status), .phy_ready(phy_ready), .edpd_en(edpd_en),
        .edpd_nlp_en(edpd_nlp_en));

    plb_mdio_host host (.sys_clk(sys_clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
                        .mdc(mdc), .mdio_in(mdio_in));

    // Free-running 50 ns clock.
    always #25 sys_clk = ~sys_clk;

    // Cuts a hung run short well after the tests should have ended.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 45000) begin
            // Blocking, so that the verdict already sees the extra mismatch.
            errors = errors + 1;
            give_verdict();
        end
    end

    // Compares one value and reports a mismatch at once.
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Writes one register through the management port.
    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        logic [15:0] r;
        host.frame(5'h01, plb_pkg::OP_WRITE, ra, d, r);
    endtask : wr

    // Reads one register and compares it with the expected value.
    task automatic rd_chk(input string what, input logic [4:0] ra, input logic [15:0] exp);
        logic [15:0] r;
        host.frame(5'h01, plb_pkg::OP_READ, ra, 16'h0000, r);
        chk(what, exp, r);
    endtask : rd_chk

    // Raises the chosen error events for one cycle.
    task automatic ev(input logic c, input logic s, input logic f);
        @(negedge sys_clk);
        {crc_error, symbol_error, false_carrier} = {c, s, f};
        @(negedge sys_clk);
        {crc_error, symbol_error, false_carrier} = 3'h0;
    endtask : ev

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    // Main sequence of tests.
    initial begin
        {sys_clk, general_loopback, count_symbol_errors, count_false_carrier} = 4'h0;
        {link_up, crc_error, symbol_error, false_carrier} = 4'h0;
        {errors, num_checks} = {32'h0, 32'h0};
        rst = 1'b1;
        repeat (6) @(negedge sys_clk);
        rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk("ctl_ports", 16'h0043, ctl_ports);
        rd_chk("loopback_control", plb_pkg::REG_LOOPBACK, 16'h1041);
        rd_chk("energy_detect_control", plb_pkg::REG_ED_CTRL, 16'h000c);
        rd_chk("rx_error_count", plb_pkg::REG_RX_ERR, 16'h0000);
        $display("test reset_values done");
        wr(plb_pkg::REG_LOOPBACK, 16'hffff);
        rd_chk("loopback_control", plb_pkg::REG_LOOPBACK, 16'h96c1);
        chk("ctl_ports", 16'h00fb, ctl_ports);
        wr(plb_pkg::REG_LOOPBACK, 16'h0000);
        rd_chk("loopback_control", plb_pkg::REG_LOOPBACK, 16'h0000);
        wr(plb_pkg::REG_ED_CTRL, 16'hfff4);
        rd_chk("energy_detect_control", plb_pkg::REG_ED_CTRL, 16'h0004);
        chk("ctl_ports", 16'h0001, ctl_ports);
        wr(plb_pkg::REG_RX_ERR, 16'h1234);
        rd_chk("rx_error_count", plb_pkg::REG_RX_ERR, 16'h0000);
        rd_chk("unmapped", 5'h16, 16'h0000);
        $display("test register_access done");
        for (int k = 0; k < 4; k++) begin
            {count_false_carrier, count_symbol_errors} = k[1:0];
            ev(1'b1, 1'b1, 1'b1);
            ev(1'b1, 1'b0, 1'b0);
            rd_chk("rx_error_count", plb_pkg::REG_RX_ERR,
                   (k[0] ? 16'h0001 : 16'h0002) + {15'h0000, k[1]});
            rd_chk("rx_error_count", plb_pkg::REG_RX_ERR, 16'h0000);
        end
        $display("test error_counter done");
        for (int i = 0; i < 7; i++) begin
            {general_loopback, link_up} = io_tab[i][4:3];
            wr(plb_pkg::REG_LOOPBACK, lb_tab[i]);
            if (i == 5) chk("phy_ready", 16'h0000, {15'h0000, phy_ready});
            repeat (60) @(negedge sys_clk);
            chk("link_status", {15'h0000, io_tab[i][2]}, {15'h0000, link_status});
            chk("phy_ready", {15'h0000, io_tab[i][1]}, {15'h0000, phy_ready});
            chk("tx_suppress", {15'h0000, io_tab[i][0]}, {15'h0000, tx_suppress});
        end
        $display("test loopback_modes done");
        give_verdict();
    end
endmodule : testbench
